// ===== verilog/mcd_datapath.sv
// Purpose: calibrates raw voltage, current and temperature counts for reporting
// Assumes: trims loaded over the trim port at start-up; one sample per cycle per path
`timescale 1ns/100ps
`default_nettype none
module mcd_datapath
   import mcd_pkg::*;
#(
   parameter int COEF_W = 8                       // threshold coefficient width
)(
   input  wire logic                sys_clk,
   input  wire logic                reset_n,
   input  wire logic                rawValid,         // new voltage sample
   input  wire mcd_kind_t           rawKind,          // which measurement
   input  wire logic [3:0]          rawIndex,         // cell number 0..13
   input  wire logic signed [31:0]  rawCount,         // converter counts
   input  wire logic signed [31:0]  offsetTrim,       // stored offset trim
   input  wire logic signed [15:0]  cellOffset,       // mV
   input  wire logic signed [15:0]  divOffset,        // user voltage unit
   input  wire logic                trimWrEn,         // factory trim load
   input  wire logic                gainWrEn,         // calibration gain write
   input  wire logic [4:0]          gainWrSel,
   input  wire logic [15:0]         gainWrData,
   input  wire logic                gainRdEn,
   input  wire logic [4:0]          gainRdSel,
   input  wire logic                unrestrictedAccessMode,
   input  wire logic                configUpdateMode,
   input  wire logic                shuntValid,
   input  wire logic signed [31:0]  shuntRaw,
   input  wire logic signed [31:0]  shuntOffsetValue,
   input  wire logic [7:0]          shuntOffsetSamples,
   input  wire logic [31:0]         currentScaleFactor, // single-precision float
   input  wire logic                tempValid,
   input  wire logic [3:0]          tempIndex,
   input  wire logic signed [15:0]  tempRaw,          // 0.1 K
   input  wire logic                tempOffWrEn,
   input  wire logic signed [15:0]  tempOffWrData,
   input  wire logic                ovCalCmd,         // overvoltage_threshold_cal_cmd
   input  wire logic                uvCalCmd,         // undervoltage_threshold_cal_cmd
   input  wire logic                comparatorTrip,   // analog, asynchronous
   input  wire logic [COEF_W-1:0]   factoryOvTrim,
   input  wire logic [COEF_W-1:0]   factoryUvTrim,
   output var  logic signed [15:0]  voltOut,
   output var  logic                voltValid,
   output var  mcd_kind_t           voltKind,
   output var  logic [3:0]          voltIndex,
   output var  logic [15:0]         gainRdData,
   output var  logic                gainRdValid,
   output var  logic signed [15:0]  currentOut,
   output var  logic                currentValid,
   output var  logic [31:0]         capacityGain,     // single-precision float
   output var  logic signed [15:0]  tempOut,
   output var  logic                tempOutValid,
   output var  logic [COEF_W-1:0]   trialCoef,        // coefficient under test
   output var  logic                trialUv,
   output var  logic                searchBusy,
   output var  logic                calDone,
   output var  logic [COEF_W-1:0]   calResult,
   output var  logic [COEF_W-1:0]   ovOverride,
   output var  logic [COEF_W-1:0]   uvOverride,
   output var  logic [COEF_W-1:0]   ovThresholdCoef,
   output var  logic [COEF_W-1:0]   uvThresholdCoef
);
   // clamp a wide signed value into the reported field
   function automatic logic signed [15:0] sat16(input logic signed [63:0] v);
      if (v > 64'(RES_MAX)) sat16 = RES_MAX;
      else if (v < 64'(RES_MIN)) sat16 = RES_MIN;
      else sat16 = v[15:0];
   endfunction : sat16

   // gain slot for a measurement kind
   function automatic logic [4:0] slotOf(input mcd_kind_t k, input logic [3:0] i);
      case (k)
         KIND_CELL:  slotOf = {1'b0, i};
         KIND_STACK: slotOf = SLOT_STACK;
         KIND_PACK:  slotOf = SLOT_PACK;
         KIND_LOAD:  slotOf = SLOT_LOAD;
         default:    slotOf = SLOT_AUX;
      endcase
   endfunction : slotOf

   logic [15:0]        trimGain   [GAIN_SLOTS];  // factory trim or default
   logic [15:0]        calGain    [GAIN_SLOTS];  // calibration writes
   logic [GAIN_SLOTS-1:0] calWritten;            // slot overwritten since reset
   logic signed [15:0] tempOffset [NUM_TEMPS];   // per-sensor offset, 0.1 K
   logic               s1Valid, s2Valid;         // voltage pipeline stages
   mcd_kind_t          s1Kind, s2Kind;
   logic [3:0]         s1Index, s2Index;
   logic [4:0]         s1Slot;
   logic signed [15:0] s1Count;                  // trim-corrected 16-bit counts
   logic signed [63:0] s2Prod;                   // gain x count / 65536
   logic               c1Valid;
   logic signed [32:0] c1Val;                    // offset-corrected shunt counts
   logic               tripMeta, tripSync;       // comparator synchroniser
   mcd_srch_t          srchState;
   logic [15:0]        settleCnt;

   // gain tables: trim loads, calibration writes in update mode only
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         for (int k = 0; k < GAIN_SLOTS; k++) begin
            trimGain[k] <= (k == int'(SLOT_AUX)) ? AUX_GAIN_DEF
                         : (k < NUM_CELLS) ? CELL_GAIN_DEF : DIV_GAIN_DEF;
            calGain[k] <= 16'h0000;
         end
         calWritten <= '0;
      end else begin
         if (trimWrEn && gainWrSel < 5'(GAIN_SLOTS)) begin
            trimGain[gainWrSel] <= gainWrData;
         end
         // writes outside update mode are ignored so a sealed pack keeps its gains
         if (gainWrEn && configUpdateMode && gainWrSel < 5'(GAIN_SLOTS)) begin
            calGain[gainWrSel]    <= gainWrData;
            calWritten[gainWrSel] <= 1'b1;
         end
      end
   end

   // gain readback; outside update mode it shows what correction uses
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         gainRdData  <= 16'h0000;
         gainRdValid <= 1'b0;
      end else begin
         gainRdValid <= gainRdEn;
         if (gainRdEn) begin
            if (gainRdSel >= 5'(GAIN_SLOTS)) gainRdData <= 16'h0000;
            else if (configUpdateMode)
               gainRdData <= calWritten[gainRdSel] ? calGain[gainRdSel] : 16'h0000;
            else
               gainRdData <= calWritten[gainRdSel] ? calGain[gainRdSel]
                                                  : trimGain[gainRdSel];
         end
      end
   end

   // stage 1: remove offset trim and fit the count to 16 bits
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         s1Valid <= 1'b0;
         s1Kind  <= KIND_CELL;
         s1Index <= 4'h0;
         s1Slot  <= 5'h00;
         s1Count <= 16'sh0000;
      end else begin
         s1Valid <= rawValid;
         if (rawValid) begin
            s1Kind  <= rawKind;
            s1Index <= rawIndex;
            s1Slot  <= slotOf(rawKind, rawIndex);
            s1Count <= sat16(64'(rawCount) - 64'(offsetTrim));
         end
      end
   end

   // stage 2: apply gain in use, scaled by 1/65536
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         s2Valid <= 1'b0;
         s2Kind  <= KIND_CELL;
         s2Index <= 4'h0;
         s2Prod  <= 64'sh0;
      end else begin
         s2Valid <= s1Valid;
         if (s1Valid) begin
            s2Kind  <= s1Kind;
            s2Index <= s1Index;
            // gain widened as a signed positive operand so negative counts stay negative
            s2Prod  <= (64'(s1Count) * 64'(signed'({1'b0, (calWritten[s1Slot]
                        ? calGain[s1Slot] : trimGain[s1Slot])})))
                       >>> GAIN_SHIFT;
         end
      end
   end

   // stage 3: subtract the matching offset, none for aux; cells in mV, dividers in user units
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         voltValid <= 1'b0;
         voltOut   <= 16'sh0000;
         voltKind  <= KIND_CELL;
         voltIndex <= 4'h0;
      end else begin
         voltValid <= s2Valid;
         if (s2Valid) begin
            voltKind  <= s2Kind;
            voltIndex <= s2Index;
            case (s2Kind)
               KIND_CELL: voltOut <= sat16(s2Prod - 64'(cellOffset));
               KIND_AUX:  voltOut <= sat16(s2Prod);
               default:   voltOut <= sat16(s2Prod - 64'(divOffset));
            endcase
         end
      end
   end

   // shunt path: offset per sample removed, then float gain applied
   always_ff @(posedge sys_clk) begin
      logic signed [63:0] p;
      int                 sh;
      p  = 64'sh0;
      sh = 0;
      if (!reset_n) begin
         c1Valid      <= 1'b0;
         c1Val        <= 33'sh0;
         currentValid <= 1'b0;
         currentOut   <= 16'sh0000;
      end else begin
         c1Valid      <= shuntValid;
         currentValid <= c1Valid;
         if (shuntValid) begin
            // a zero sample count is read as one to keep the divide defined;
            // both arms are signed so a negative offset divides as signed
            c1Val <= 33'(shuntRaw) - 33'(shuntOffsetValue / ((shuntOffsetSamples == 8'h00)
                     ? 32'sd1 : $signed(32'(shuntOffsetSamples))));
         end
         if (c1Valid) begin
            if (currentScaleFactor[30:23] == 8'h00) currentOut <= 16'sh0000;
            else begin
               p  = 64'(c1Val) * 64'({1'b1, currentScaleFactor[22:0]});
               if (currentScaleFactor[31]) p = -p;
               sh = int'(currentScaleFactor[30:23]) - FLT_SHIFT;
               if (sh >= 0)
                  currentOut <= (p == 64'sh0) ? 16'sh0000 : (sh > 15) ?
                     (p < 0 ? RES_MIN : RES_MAX) : sat16(p <<< sh);
               else
                  currentOut <= sat16(p >>> ((-sh > 63) ? 63 : -sh));
            end
         end
      end
   end

   // capacity gain follows the current gain at all times
   always_ff @(posedge sys_clk) begin
      logic [47:0] m;
      m = 48'({1'b1, currentScaleFactor[22:0]}) * 48'(CAP_MANT);
      if (!reset_n) capacityGain <= 32'h0000_0000;
      else if (currentScaleFactor[30:23] == 8'h00) capacityGain <= 32'h0000_0000;
      else if (m[47])
         capacityGain <= {currentScaleFactor[31],
                          8'(currentScaleFactor[30:23] + CAP_EXP + 8'h01), m[46:24]};
      else
         capacityGain <= {currentScaleFactor[31],
                          8'(currentScaleFactor[30:23] + CAP_EXP), m[45:23]};
   end

   // temperature offsets and correction
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         for (int k = 0; k < NUM_TEMPS; k++) tempOffset[k] <= 16'sh0000;
         tempOut      <= 16'sh0000;
         tempOutValid <= 1'b0;
      end else begin
         if (tempOffWrEn && tempIndex < 4'(NUM_TEMPS)) tempOffset[tempIndex] <= tempOffWrData;
         tempOutValid <= tempValid;
         if (tempValid)  // out-of-range index reports the result unchanged
            tempOut <= sat16(64'(tempRaw) + ((tempIndex < 4'(NUM_TEMPS))
                       ? 64'(tempOffset[tempIndex]) : 64'sh0));
      end
   end

   // comparator output is analog-timed, so it is synchronised first
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         tripMeta <= 1'b0;
         tripSync <= 1'b0;
      end else begin
         tripMeta <= comparatorTrip;
         tripSync <= tripMeta;
      end
   end

   // threshold search: step the coefficient up until the comparator flips.
   // overvoltage stops when the trip clears, undervoltage when it sets.
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         srchState  <= SRCH_IDLE;
         trialCoef  <= '0;
         trialUv    <= 1'b0;
         settleCnt  <= 16'h0000;
         calDone    <= 1'b0;
         calResult  <= '0;
         ovOverride <= '0;
         uvOverride <= '0;
      end else begin
         calDone <= 1'b0;
         case (srchState)
            SRCH_IDLE: begin
               // commands only count in update mode; the host holds the level applied
               if ((ovCalCmd || uvCalCmd) && configUpdateMode) begin
                  trialUv   <= uvCalCmd && !ovCalCmd;
                  trialCoef <= COEF_W'(1);
                  settleCnt <= 16'(SETTLE_CYC);
                  srchState <= SRCH_SETTLE;
               end
            end
            SRCH_SETTLE: begin
               if (settleCnt != 16'h0000) settleCnt <= settleCnt - 16'h0001;
               else if (tripSync == trialUv || &trialCoef) srchState <= SRCH_DONE;
               else begin
                  trialCoef <= trialCoef + COEF_W'(1);
                  settleCnt <= 16'(SETTLE_CYC);
               end
            end
            SRCH_DONE: begin
               calDone   <= 1'b1;
               calResult <= trialCoef;
               if (trialUv) uvOverride <= trialCoef;
               else ovOverride <= trialCoef;
               srchState <= SRCH_IDLE;
            end
            default: srchState <= SRCH_IDLE;
         endcase
      end
   end

   // thresholds in force and busy flag
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         ovThresholdCoef <= '0;
         uvThresholdCoef <= '0;
         searchBusy      <= 1'b0;
      end else begin
         ovThresholdCoef <= (ovOverride != '0) ? ovOverride : factoryOvTrim;
         uvThresholdCoef <= (uvOverride != '0) ? uvOverride : factoryUvTrim;
         searchBusy      <= (srchState != SRCH_IDLE);
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   property p_voltLatency;
      rawValid |-> ##3 voltValid;
   endproperty
   a_voltLatency: assert property (p_voltLatency) else $error("voltage result late");
   property p_auxNoOffset;
      s2Valid && s2Kind == KIND_AUX |=> voltOut == sat16($past(s2Prod));
   endproperty
   a_auxNoOffset: assert property (p_auxNoOffset) else $error("aux offset applied");
   property p_cellOffset;
      s2Valid && s2Kind == KIND_CELL |=> voltOut == sat16($past(s2Prod) - 64'($past(cellOffset)));
   endproperty
   a_cellOffset: assert property (p_cellOffset) else $error("cell offset wrong");
   property p_saturate;
      s2Valid && s2Kind != KIND_CELL && s2Kind != KIND_AUX
         && s2Prod - 64'(divOffset) > 64'(RES_MAX) |=> voltOut == RES_MAX;
   endproperty
   a_saturate: assert property (p_saturate) else $error("result wrapped");
   property p_rdZero;
      gainRdEn && configUpdateMode && gainRdSel < 5'(GAIN_SLOTS) && !calWritten[gainRdSel]
         |=> gainRdValid && gainRdData == 16'h0000;
   endproperty
   a_rdZero: assert property (p_rdZero) else $error("unwritten gain not zero");
   property p_rdTrim;
      gainRdEn && !configUpdateMode && unrestrictedAccessMode && gainRdSel < 5'(GAIN_SLOTS)
         && !calWritten[gainRdSel] |=> gainRdData == trimGain[$past(gainRdSel)];
   endproperty
   a_rdTrim: assert property (p_rdTrim) else $error("trim readback wrong");
   property p_ovOverride;
      ovOverride != '0 |=> ovThresholdCoef == $past(ovOverride);
   endproperty
   a_ovOverride: assert property (p_ovOverride) else $error("override not used");
   property p_calStore;
      srchState == SRCH_DONE && !trialUv |=> calDone && ovOverride == calResult;
   endproperty
   a_calStore: assert property (p_calStore) else $error("override not stored");
   property p_tempLatency;
      tempValid |=> tempOutValid;
   endproperty
   a_tempLatency: assert property (p_tempLatency) else $error("temperature late");
endmodule : mcd_datapath
`default_nettype wire

// ===== verilog/mcd_pkg.sv
// Purpose: shared constants and types for the measurement calibration datapath
// Assumes: 100 MHz sys_clk, 16-bit reported signed results
// Notes:   gain slots 0..13 are cells, then stack, pack, load, aux
package mcd_pkg;
   localparam int          CLK_MHZ        = 100;          // system clock rate
   localparam int          NUM_CELLS      = 14;           // cell gain slots
   localparam int          GAIN_SLOTS     = 18;           // cells plus stack, pack, load and aux
   localparam logic [4:0]  SLOT_STACK     = 5'h0E;        // stack-top gain slot
   localparam logic [4:0]  SLOT_PACK      = 5'h0F;        // pack-terminal gain slot
   localparam logic [4:0]  SLOT_LOAD      = 5'h10;        // load-pin gain slot
   localparam logic [4:0]  SLOT_AUX       = 5'h11;        // auxiliary input gain slot
   localparam logic [15:0] CELL_GAIN_DEF  = 16'h3079;     // 12409, cells at 5 x 1.25 V
   localparam logic [15:0] AUX_GAIN_DEF   = 16'h1046;     // 4166, aux at 1.667 x 1.25 V
   localparam logic [15:0] DIV_GAIN_DEF   = 16'h3079;     // plain default for dividers
   localparam int          GAIN_SHIFT     = 16;           // divide by 65536
   localparam int          NUM_TEMPS      = 10;           // temperature offset slots
   localparam logic signed [15:0] RES_MAX = 16'sh7FFF;    // top of reported field
   localparam logic signed [15:0] RES_MIN = -16'sh8000;   // bottom of reported field
   localparam logic [23:0] CAP_MANT       = 24'h91A2B4;   // 298261.6178 significand
   localparam logic [7:0]  CAP_EXP        = 8'h12;        // 298261.6178 exponent, 18
   localparam int          FLT_SHIFT      = 150;          // float bias plus fraction bits
   localparam int          SETTLE_NS      = 1000;         // comparator settle per step
   localparam int          SETTLE_CYC     = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   typedef enum logic [2:0] {KIND_CELL, KIND_STACK, KIND_PACK, KIND_LOAD, KIND_AUX} mcd_kind_t;
   typedef enum logic [1:0] {SRCH_IDLE, SRCH_SETTLE, SRCH_DONE} mcd_srch_t;
endpackage : mcd_pkg

// ===== bench/mcd_cmp_model.sv
// Purpose: cell comparator across the top cell taps during threshold search
// Assumes: applied level is given as a threshold coefficient
// Notes:   plain level; follows the trial coefficient with no delay
`timescale 1ns/100ps
`default_nettype none
module mcd_cmp_model (
   input  wire logic [7:0] trialCoef,
   input  wire logic       trialUv,
   input  wire logic [7:0] target,
   output var  logic       comparatorTrip
);
   // trips below target when hunting overvoltage, at or above it for undervoltage
   always_comb begin
      comparatorTrip = trialUv ? (trialCoef >= target) : (trialCoef < target);
   end
endmodule : mcd_cmp_model
`default_nettype wire

// ===== bench/mcd_datapath_test.sv
// Purpose: self-checking bench for the calibration datapath
// Assumes: COEF_W of 8, settle of 100 cycles per search step
// Notes:   expected results queue up and pop at each valid strobe
`timescale 1ns/100ps
`default_nettype none
module mcd_datapath_test import mcd_pkg::*; ;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic rawValid, trimWrEn, gainWrEn, gainRdEn, unrestrictedAccessMode, configUpdateMode;
   logic shuntValid, tempValid, tempOffWrEn, ovCalCmd, uvCalCmd, voltValid, gainRdValid;
   logic currentValid, tempOutValid, trialUv, searchBusy, calDone;
   wire comparatorTrip;
   mcd_kind_t rawKind, voltKind;
   logic [3:0] rawIndex, tempIndex, voltIndex;
   logic signed [31:0] rawCount, offsetTrim, shuntRaw, shuntOffsetValue;
   logic signed [15:0] cellOffset, divOffset, tempRaw, tempOffWrData, voltOut, currentOut, tempOut;
   logic [4:0] gainWrSel, gainRdSel;
   logic [15:0] gainWrData, gainRdData;
   logic [7:0] shuntOffsetSamples, factoryOvTrim, factoryUvTrim, trialCoef, calResult, target;
   logic [7:0] ovOverride, uvOverride, ovThresholdCoef, uvThresholdCoef;
   logic [31:0] currentScaleFactor, capacityGain;
   logic [31:0] seed = 32'h000082DD;           // fixed start of the random sequence
   int numErrors = 0;
   int checksDone = 0;
   int trimGain[18], calGain[18], tempOff[10];  // reference copies of the gain and offset stores
   bit written[18];                             // calibration gain written per slot
   logic [22:0] voltQ[$];                       // kind, index and value awaited
   logic [15:0] gainQ[$], curQ[$], tempQ[$];
   // free-running 100 MHz clock
   always #5 sys_clk = ~sys_clk;
   mcd_datapath i_dut (
      .sys_clk, .reset_n, .rawValid, .rawKind, .rawIndex, .rawCount, .offsetTrim, .cellOffset,
      .divOffset, .trimWrEn, .gainWrEn, .gainWrSel, .gainWrData, .gainRdEn, .gainRdSel,
      .unrestrictedAccessMode, .configUpdateMode, .shuntValid, .shuntRaw, .shuntOffsetValue,
      .shuntOffsetSamples, .currentScaleFactor, .tempValid, .tempIndex, .tempRaw, .tempOffWrEn,
      .tempOffWrData, .ovCalCmd, .uvCalCmd, .comparatorTrip, .factoryOvTrim, .factoryUvTrim,
      .voltOut, .voltValid, .voltKind, .voltIndex, .gainRdData, .gainRdValid, .currentOut,
      .currentValid, .capacityGain, .tempOut, .tempOutValid, .trialCoef, .trialUv, .searchBusy,
      .calDone, .calResult, .ovOverride, .uvOverride, .ovThresholdCoef, .uvThresholdCoef);
   mcd_cmp_model i_cmp (.trialCoef, .trialUv, .target, .comparatorTrip);
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // clamp to the signed 16-bit reported field
   function automatic logic [15:0] sat(input longint v);
      return v > 32767 ? 16'h7FFF : v < -32768 ? 16'h8000 : 16'(v);
   endfunction : sat
   task automatic tick;
      @(posedge sys_clk);
   endtask : tick
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      checksDone++;
      if (g !== e) begin
         numErrors++;
         $display("ERROR at %0t: got %h expected %h", $time, g, e);
      end
   endtask : check
   task automatic testDone;
      if (numErrors == 0 && checksDone > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : testDone
   // trim load or calibration write; the latter only counts in update mode
   task automatic write_gain(input int s, input logic [15:0] d, input bit trim);
      gainWrSel <= 5'(s);
      gainWrData <= d;
      trimWrEn <= trim;
      gainWrEn <= !trim;
      if (trim) trimGain[s] = d;
      else if (configUpdateMode) begin
         calGain[s] = d;
         written[s] = 1'b1;
      end
      tick;
      trimWrEn <= 1'b0;
      gainWrEn <= 1'b0;
      tick;
   endtask : write_gain
   task automatic read_gain(input int s);
      gainRdSel <= 5'(s);
      gainRdEn <= 1'b1;
      gainQ.push_back(s >= 18 ? 16'h0000 : written[s] ? 16'(calGain[s]) :
                      configUpdateMode ? 16'h0000 : 16'(trimGain[s]));
      tick;
      gainRdEn <= 1'b0;
      tick;
   endtask : read_gain
   // leaves rawValid high so calls run back to back
   task automatic send_volt(input int k, input int i, input logic signed [31:0] c);
      int s;
      longint v;
      s = k == 0 ? i : 13 + k;
      v = longint'($signed(sat(longint'(c) - longint'(offsetTrim))));
      v = (v * (written[s] ? calGain[s] : trimGain[s])) >>> 16;
      v = v - (k == 0 ? cellOffset : k == 4 ? 0 : divOffset);
      voltQ.push_back({3'(k), 4'(i), sat(v)});
      rawValid <= 1'b1;
      rawKind <= mcd_kind_t'(k);
      rawIndex <= 4'(i);
      rawCount <= c;
      tick;
   endtask : send_volt
   task automatic send_cur(input logic signed [23:0] r, o, input logic [7:0] k, input logic [31:0] f);
      longint p;
      p = longint'(r) - longint'(o) / int'(k == 0 ? 8'h01 : k);
      p = p * longint'({1'b1, f[22:0]});
      if (f[31]) p = -p;
      curQ.push_back(sat(p >>> (150 - f[30:23])));
      shuntValid <= 1'b1;
      shuntRaw <= 32'(r);
      shuntOffsetValue <= 32'(o);
      shuntOffsetSamples <= k;
      currentScaleFactor <= f;
      tick;
      shuntValid <= 1'b0;
      tick;
      check({capacityGain[31], 8'(capacityGain[30:23] - f[30:23] - 8'h12) >> 1}, {f[31], 8'h00});
   endtask : send_cur
   task automatic send_temp(input int i, input logic [15:0] d, input logic [15:0] t);
      tempIndex <= 4'(i);
      tempOffWrData <= d;
      tempOffWrEn <= 1'b1;
      if (i < 10) tempOff[i] = int'($signed(d));
      tick;
      tempOffWrEn <= 1'b0;
      tempValid <= 1'b1;
      tempRaw <= t;
      tempQ.push_back(sat(longint'($signed(t)) + (i < 10 ? tempOff[i] : 0)));
      tick;
      tempValid <= 1'b0;
      tick;
   endtask : send_temp
   task automatic run_search(input bit uv, input bit cfg, input int t);
      int w;
      configUpdateMode <= cfg;
      target <= 8'(t);
      tick;
      ovCalCmd <= !uv;
      uvCalCmd <= uv;
      tick;
      ovCalCmd <= 1'b0;
      uvCalCmd <= 1'b0;
      for (w = 0; w < (cfg ? 3000 : 20) && calDone !== 1'b1; w++) tick;
      if (cfg) begin
         check(calResult, t);
         check(uv ? uvOverride : ovOverride, t);
         tick;
         tick;
         check(uv ? uvThresholdCoef : ovThresholdCoef, t);
      end else begin
         check({searchBusy, ovOverride}, 9'h000);
      end
   endtask : run_search
   // each strobe must match the oldest expectation of its kind
   always @(posedge sys_clk) begin
      if (voltValid === 1'b1) check({voltKind, voltIndex, voltOut}, voltQ.pop_front());
      if (gainRdValid === 1'b1) check(gainRdData, gainQ.pop_front());
      if (currentValid === 1'b1) check({currentOut}, curQ.pop_front());
      if (tempOutValid === 1'b1) check({tempOut}, tempQ.pop_front());
   end
   initial begin : main
      int n;
      {rawValid, trimWrEn, gainWrEn, gainRdEn, shuntValid, tempValid, tempOffWrEn} = '0;
      {ovCalCmd, uvCalCmd, configUpdateMode, unrestrictedAccessMode, rawIndex, tempIndex} = '0;
      {rawCount, offsetTrim, shuntRaw, shuntOffsetValue, cellOffset, divOffset, tempRaw} = '0;
      {tempOffWrData, gainWrSel, gainRdSel, gainWrData, shuntOffsetSamples, target} = '0;
      currentScaleFactor = '0;
      rawKind = KIND_CELL;
      factoryOvTrim = 8'h5A;
      factoryUvTrim = 8'h3C;
      for (n = 0; n < 18; n++) trimGain[n] = n == 17 ? 4166 : 12409;
      repeat (12) tick;
      reset_n <= 1'b1;
      unrestrictedAccessMode <= 1'b1;
      repeat (3) tick;
      check({ovThresholdCoef, uvThresholdCoef}, {factoryOvTrim, factoryUvTrim});
      for (n = 0; n < 19; n++) read_gain(n);
      write_gain(1, 16'h2F00, 1'b1);
      read_gain(1);
      configUpdateMode <= 1'b1;
      tick;
      for (n = 0; n < 18; n += 3) write_gain(n, 16'(9000 + rnd() % 9000), 1'b0);
      for (n = 0; n < 19; n++) read_gain(n);
      configUpdateMode <= 1'b0;
      tick;
      write_gain(2, 16'h1234, 1'b0);
      for (n = 0; n < 19; n++) read_gain(n);
      // cell offset kept small, divider offset far negative so positive results clip
      cellOffset <= $signed(16'(rnd())) >>> 4;
      divOffset <= 16'sh8000 + 16'(rnd() % 4096);
      offsetTrim <= 32'(rnd() >> 20);
      tick;
      for (n = 0; n < 60; n++) send_volt(n % 5, rnd() % 14, n % 7 == 0 ? 32'h7FFFFFFF : rnd());
      rawValid <= 1'b0;
      repeat (4) tick;
      for (n = 0; n < 20; n++) send_cur(24'(rnd()), 24'(rnd()), n == 0 ? 8'h00 : 8'(rnd()),
                                        {1'(rnd()), 8'(131 + n), 23'(rnd())});
      send_cur(24'(rnd()), 24'(rnd()), 8'h10, 32'h40EF41F2);
      for (n = 0; n < 12; n++) send_temp(n, 16'(rnd()), 16'(rnd()));
      run_search(1'b0, 1'b0, 5);
      run_search(1'b0, 1'b1, 6);
      run_search(1'b1, 1'b1, 4);
      check(voltQ.size() + gainQ.size() + curQ.size() + tempQ.size(), 0);
      testDone;
   end
   // a hang counts as a mismatch; the run needs about 1340 cycles
   initial begin : watchdog
      repeat (10000) @(posedge sys_clk);
      numErrors++;
      testDone;
   end
endmodule : mcd_datapath_test
`default_nettype wire
